// [hw/dsgate_access_check.sv]
// Answers peripheral accesses, faulting those aimed at an unclocked unit
`timescale 1ns/10ps
module dsgate_access_check (
  input wire logic i_clk,                            // System clock
  input wire logic i_reset,                          // Async reset, active high
  input wire logic i_ce,                             // Clock enable
  input wire logic [31:0] i_enables,                 // Effective unit enables
  input wire dsgate_pkg::dsgate_access_s i_access,   // Access request
  output logic o_done,                               // Access completed normally
  output logic o_fault                               // Access answered with bus fault
);

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_done <= 1'b0;
      o_fault <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= i_access.valid && i_enables[i_access.unit];
      o_fault <= i_access.valid && !i_enables[i_access.unit];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fault_when_gated;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && i_access.valid && !i_enables[i_access.unit]) |=> (o_fault && !o_done);
  endproperty
  a_fault_when_gated: assert property (p_fault_when_gated)
    else $error("access to gated unit not faulted");

  property p_ok_when_clocked;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && i_access.valid && i_enables[i_access.unit]) |=> (o_done && !o_fault);
  endproperty
  a_ok_when_clocked: assert property (p_ok_when_clocked)
    else $error("access to clocked unit not completed");

  property p_cover_fault;
    @(posedge i_clk) disable iff (i_reset)
    o_fault;
  endproperty
  c_cover_fault: cover property (p_cover_fault);

endmodule

// [hw/dsgate_pkg.sv]
// Constants and types shared by the deep-sleep unit clock gate block
package dsgate_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE_ADDR = 32'h400fe000;
  localparam logic [31:0] OFF_CONFIG = 32'h00000060;
  localparam logic [31:0] OFF_RUN = 32'h00000100;
  localparam logic [31:0] OFF_SLEEP = 32'h00000110;
  localparam logic [31:0] OFF_DEEP = 32'h00000124;
  localparam logic [31:0] OFF_STATUS = 32'h00000128;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] GATE_MASK = 32'h07071117;
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam logic [31:0] CONFIG_MASK = 32'h00000001;
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;
  localparam int unsigned AUTO_GATE_POS = 0;
  localparam int unsigned SERIAL_ZERO_POS = 0;
  localparam int unsigned SERIAL_ONE_POS = 1;
  localparam int unsigned UNIT_COUNT = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} dsgate_mode_e;
  typedef enum logic [2:0] {SEL_NONE, SEL_CONFIG, SEL_RUN, SEL_SLEEP, SEL_DEEP,
    SEL_STATUS} dsgate_sel_e;

  typedef struct packed {
    logic sleep;
    logic deep;
  } dsgate_power_s;

  typedef struct packed {
    logic valid;
    logic [4:0] unit;
  } dsgate_access_s;

endpackage

// [hw/dsgate_top.sv]
// Deep-sleep unit clock gating register with run and sleep companions
`timescale 1ns/10ps
module dsgate_top (
  input wire logic i_clk,                            // System clock, 50 MHz
  input wire logic i_reset,                          // Async reset, active high
  input wire logic i_ce,                             // Clock enable, freezes all state
  input wire logic i_awvalid,                        // Write address valid
  output logic o_awready,                            // Write address ready
  input wire logic [31:0] i_awaddr,                  // Write byte address
  input wire logic i_wvalid,                         // Write data valid
  output logic o_wready,                             // Write data ready
  input wire logic [31:0] i_wdata,                   // Write data
  input wire logic [3:0] i_wstrb,                    // Write byte strobes
  output logic o_bvalid,                             // Write response valid
  input wire logic i_bready,                         // Write response ready
  output logic [1:0] o_bresp,                        // Write response code
  input wire logic i_arvalid,                        // Read address valid
  output logic o_arready,                            // Read address ready
  input wire logic [31:0] i_araddr,                  // Read byte address
  output logic o_rvalid,                             // Read data valid
  input wire logic i_rready,                         // Read data ready
  output logic [31:0] o_rdata,                       // Read data
  output logic [1:0] o_rresp,                        // Read response code
  input wire dsgate_pkg::dsgate_power_s i_power,     // Power mode requests
  input wire dsgate_pkg::dsgate_access_s i_access,   // Peripheral access request
  output logic [31:0] o_unit_clk_en,                 // Per-unit clock enables
  output logic o_deep_active,                        // Deep-sleep mode in force
  output logic o_access_done,                        // Peripheral access completed
  output logic o_access_fault                        // Peripheral access faulted
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic dsgate_pkg::dsgate_sel_e decode_sel(input logic [31:0] addr);
    if (addr == dsgate_pkg::BASE_ADDR + dsgate_pkg::OFF_CONFIG)
      return dsgate_pkg::SEL_CONFIG;
    else if (addr == dsgate_pkg::BASE_ADDR + dsgate_pkg::OFF_RUN)
      return dsgate_pkg::SEL_RUN;
    else if (addr == dsgate_pkg::BASE_ADDR + dsgate_pkg::OFF_SLEEP)
      return dsgate_pkg::SEL_SLEEP;
    else if (addr == dsgate_pkg::BASE_ADDR + dsgate_pkg::OFF_DEEP)
      return dsgate_pkg::SEL_DEEP;
    else if (addr == dsgate_pkg::BASE_ADDR + dsgate_pkg::OFF_STATUS)
      return dsgate_pkg::SEL_STATUS;
    else
      return dsgate_pkg::SEL_NONE;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
    input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] bytes;
    bytes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((new_v & bytes) | (old_v & ~bytes)) & mask;
  endfunction

  function automatic logic i_bvalid_done();
    return o_bvalid && i_bready;
  endfunction

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  dsgate_pkg::dsgate_sel_e wr_sel;

  // Address and data are latched independently; the write lands once both are held
  assign wr_fire = aw_have_q && w_have_q && !o_bvalid;
  assign wr_sel = decode_sel(aw_addr_q);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      o_awready <= 1'b1;
    end
    else if (i_ce)
    begin
      if (i_awvalid && o_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      else if (wr_fire)
      begin
        aw_have_q <= 1'b0;
      end
      if (i_bvalid_done())
        o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      o_wready <= 1'b1;
    end
    else if (i_ce)
    begin
      if (i_wvalid && o_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
        o_wready <= 1'b0;
      end
      else if (wr_fire)
      begin
        w_have_q <= 1'b0;
      end
      if (i_bvalid_done())
        o_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= dsgate_pkg::RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (wr_fire)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= (wr_sel == dsgate_pkg::SEL_NONE) ? dsgate_pkg::RESP_SLVERR
          : dsgate_pkg::RESP_OKAY;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Gate registers
  // ----------------------------------------------------------------
  logic [31:0] config_q;
  logic [31:0] run_q;
  logic [31:0] sleep_q;
  logic [31:0] deep_q;

  // Reserved bits never store, so they read back zero
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      config_q <= dsgate_pkg::CONFIG_RESET;
      run_q <= dsgate_pkg::GATE_RESET;
      sleep_q <= dsgate_pkg::GATE_RESET;
      deep_q <= dsgate_pkg::GATE_RESET;
    end
    else if (i_ce && wr_fire)
    begin
      if (wr_sel == dsgate_pkg::SEL_CONFIG)
        config_q <= merge_strb(config_q, w_data_q, w_strb_q, dsgate_pkg::CONFIG_MASK);
      else if (wr_sel == dsgate_pkg::SEL_RUN)
        run_q <= merge_strb(run_q, w_data_q, w_strb_q, dsgate_pkg::GATE_MASK);
      else if (wr_sel == dsgate_pkg::SEL_SLEEP)
        sleep_q <= merge_strb(sleep_q, w_data_q, w_strb_q, dsgate_pkg::GATE_MASK);
      else if (wr_sel == dsgate_pkg::SEL_DEEP)
        deep_q <= merge_strb(deep_q, w_data_q, w_strb_q, dsgate_pkg::GATE_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Power mode and effective enables
  // ----------------------------------------------------------------
  dsgate_pkg::dsgate_mode_e mode_q;
  logic auto_gate;

  assign auto_gate = config_q[dsgate_pkg::AUTO_GATE_POS];

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      mode_q <= dsgate_pkg::MODE_RUN;
    else if (i_ce)
    begin
      case (mode_q)
        dsgate_pkg::MODE_RUN,
        dsgate_pkg::MODE_SLEEP,
        dsgate_pkg::MODE_DEEP:
        begin
          if (i_power.deep)
            mode_q <= dsgate_pkg::MODE_DEEP;
          else if (i_power.sleep)
            mode_q <= dsgate_pkg::MODE_SLEEP;
          else
            mode_q <= dsgate_pkg::MODE_RUN;
        end
        default: mode_q <= dsgate_pkg::MODE_RUN;
      endcase
    end
  end

  // Enables are registered, so a clock-enable glitch can never reach a unit
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_unit_clk_en <= dsgate_pkg::GATE_RESET;
      o_deep_active <= 1'b0;
    end
    else if (i_ce)
    begin
      o_deep_active <= auto_gate && (mode_q == dsgate_pkg::MODE_DEEP);
      if (auto_gate && mode_q == dsgate_pkg::MODE_DEEP)
        o_unit_clk_en <= deep_q;
      else if (auto_gate && mode_q == dsgate_pkg::MODE_SLEEP)
        o_unit_clk_en <= sleep_q;
      else
        o_unit_clk_en <= run_q;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  dsgate_pkg::dsgate_sel_e rd_sel;
  assign rd_sel = decode_sel(i_araddr);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= dsgate_pkg::RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= dsgate_pkg::RESP_OKAY;
        if (rd_sel == dsgate_pkg::SEL_CONFIG)
          o_rdata <= config_q;
        else if (rd_sel == dsgate_pkg::SEL_RUN)
          o_rdata <= run_q;
        else if (rd_sel == dsgate_pkg::SEL_SLEEP)
          o_rdata <= sleep_q;
        else if (rd_sel == dsgate_pkg::SEL_DEEP)
          o_rdata <= deep_q;
        else if (rd_sel == dsgate_pkg::SEL_STATUS)
          o_rdata <= o_unit_clk_en;
        else
        begin
          o_rdata <= 32'h00000000;
          o_rresp <= dsgate_pkg::RESP_SLVERR;
        end
      end
      else if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Peripheral access answer
  // ----------------------------------------------------------------
  dsgate_access_check u_access_check (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_enables(o_unit_clk_en),
    .i_access(i_access),
    .o_done(o_access_done),
    .o_fault(o_access_fault)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic seen_ce_q;
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      seen_ce_q <= 1'b0;
    else if (i_ce)
      seen_ce_q <= 1'b1;
  end

  property p_reset_zero;
    @(posedge i_clk) disable iff (i_reset)
    !seen_ce_q |-> (deep_q == 32'h00000000 && o_unit_clk_en == 32'h00000000);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("state not zero after reset");

  property p_deep_applied;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && auto_gate && mode_q == dsgate_pkg::MODE_DEEP) |=> (o_unit_clk_en == $past(deep_q));
  endproperty
  a_deep_applied: assert property (p_deep_applied)
    else $error("deep-sleep gates not applied");

  property p_run_without_auto;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && !auto_gate) |=> (o_unit_clk_en == $past(run_q));
  endproperty
  a_run_without_auto: assert property (p_run_without_auto)
    else $error("run gates not in force without auto gating");

  property p_withheld;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && auto_gate && mode_q == dsgate_pkg::MODE_DEEP && !deep_q[0])
      |=> !o_unit_clk_en[0] ##1 (!$past(i_ce) || !$past(auto_gate)
      || $past(mode_q) != dsgate_pkg::MODE_DEEP || o_unit_clk_en[0] == $past(deep_q[0]));
  endproperty
  a_withheld: assert property (p_withheld)
    else $error("clock not withheld for cleared bit");

  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_reset)
    ((deep_q | run_q | sleep_q) & ~dsgate_pkg::GATE_MASK) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved gate bit set");

  property p_serial_bits;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && wr_fire && wr_sel == dsgate_pkg::SEL_DEEP && w_strb_q[0])
      |=> (deep_q[1:0] == $past(w_data_q[1:0]));
  endproperty
  a_serial_bits: assert property (p_serial_bits)
    else $error("serial port gate bits not written");

  property p_deep_read;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && i_arvalid && o_arready && rd_sel == dsgate_pkg::SEL_DEEP)
      |=> (o_rvalid && o_rresp == dsgate_pkg::RESP_OKAY && o_rdata == $past(deep_q));
  endproperty
  a_deep_read: assert property (p_deep_read)
    else $error("deep-sleep register read wrong");

  property p_cover_deep;
    @(posedge i_clk) disable iff (i_reset)
    o_deep_active && o_unit_clk_en != 32'h00000000;
  endproperty
  c_cover_deep: cover property (p_cover_deep);

  property p_cover_unmapped;
    @(posedge i_clk) disable iff (i_reset)
    o_rvalid && o_rresp == dsgate_pkg::RESP_SLVERR;
  endproperty
  c_cover_unmapped: cover property (p_cover_unmapped);

endmodule

// [testbench/testbench.sv]
// Self-checking bench for the deep-sleep unit clock gate block
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------------------------
  // Ports and bench state
  // ------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_ce = 1'b1;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
  logic [3:0] i_wstrb = 4'h0;
  dsgate_pkg::dsgate_power_s i_power = '0;
  dsgate_pkg::dsgate_access_s i_access = '0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, o_unit_clk_en;
  logic o_deep_active, o_access_done, o_access_fault;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] seed = 16'h9452;
  logic [31:0] m_run = 32'h0, m_sleep = 32'h0, m_deep = 32'h0, m_cfg = 32'h0;
  logic [31:0] rd, rv, ev;
  logic [1:0] resp;
  localparam logic [31:0] MASK = 32'h07071117;
  localparam logic [31:0] A_CFG = 32'h400fe060;
  localparam logic [31:0] A_RUN = 32'h400fe100;
  localparam logic [31:0] A_SLP = 32'h400fe110;
  localparam logic [31:0] A_DEEP = 32'h400fe124;
  localparam logic [31:0] A_STAT = 32'h400fe128;
  localparam logic [31:0] A_BAD = 32'h400fe200;

  dsgate_top dsgate_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_power(i_power), .i_access(i_access), .o_unit_clk_en(o_unit_clk_en),
    .o_deep_active(o_deep_active), .o_access_done(o_access_done),
    .o_access_fault(o_access_fault));

  always #10 i_clk = ~i_clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction

  function automatic logic [31:0] rand32();
    logic [31:0] r;
    seed = lfsr(seed);
    r[15:0] = seed;
    seed = lfsr(seed);
    r[31:16] = seed;
    return r;
  endfunction

  // Deep request beats sleep; both ignored unless auto gating is on
  function automatic logic [31:0] exp_en(input logic [1:0] pw);
    if (m_cfg[0] && pw[0])
      return m_deep;
    if (m_cfg[0] && pw[1])
      return m_sleep;
    return m_run;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Handshakes are judged right after the rising edge, before the design's new values land
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done;
    logic w_done;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!aw_done || !w_done)
    begin
      @(posedge i_clk);
      if (i_awvalid && o_awready && i_ce)
      begin
        aw_done = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready && i_ce)
      begin
        w_done = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (!(o_bvalid && i_ce));
    resp = o_bresp;
    i_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a);
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (!(o_arready && i_ce));
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (!(o_rvalid && i_ce));
    rd = o_rdata;
    resp = o_rresp;
    i_rready <= 1'b0;
  endtask

  task automatic read_check(input string name, input logic [31:0] a, input logic [31:0] exp);
    axi_read(a);
    check(name, rd, exp);
    check("rresp", {30'h0, resp}, {30'h0, dsgate_pkg::RESP_OKAY});
  endtask

  task automatic poke(input logic [4:0] unit, input logic en);
    @(posedge i_clk);
    i_access <= '{valid: 1'b1, unit: unit};
    @(posedge i_clk);
    i_access <= '0;
    #1;
    check("access_done", {31'h0, o_access_done}, {31'h0, en});
    check("access_fault", {31'h0, o_access_fault}, {31'h0, ~en});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    check("enables_reset", o_unit_clk_en, 32'h0);
    read_check("deep_reset", A_DEEP, 32'h0);
    read_check("run_reset", A_RUN, 32'h0);
    read_check("sleep_reset", A_SLP, 32'h0);
    poke(5'd0, 1'b0);
    // Serial port bits alone, then every bit set
    axi_write(A_DEEP, 32'h00000003, 4'hf);
    read_check("deep_serial", A_DEEP, 32'h00000003);
    axi_write(A_DEEP, 32'hffffffff, 4'hf);
    check("bresp", {30'h0, resp}, {30'h0, dsgate_pkg::RESP_OKAY});
    m_deep = MASK;
    read_check("deep_all", A_DEEP, m_deep);
    // Byte strobes keep unselected lanes
    rv = rand32();
    axi_write(A_DEEP, rv, 4'h1);
    m_deep = ((m_deep & 32'hffffff00) | (rv & 32'h000000ff)) & MASK;
    read_check("deep_strobe", A_DEEP, m_deep);
    // Unmapped place answers with an error and changes nothing
    axi_write(A_BAD, 32'hffffffff, 4'hf);
    check("bresp_bad", {30'h0, resp}, {30'h0, dsgate_pkg::RESP_SLVERR});
    axi_read(A_BAD);
    check("rdata_bad", rd, 32'h0);
    check("rresp_bad", {30'h0, resp}, {30'h0, dsgate_pkg::RESP_SLVERR});
    read_check("deep_kept", A_DEEP, m_deep);
    for (int it = 0; it < 6; it++)
    begin
      m_run = rand32() & MASK;
      m_sleep = rand32() & MASK;
      m_deep = rand32() & MASK;
      m_cfg = {31'h0, it[0]};
      axi_write(A_RUN, m_run, 4'hf);
      axi_write(A_SLP, m_sleep, 4'hf);
      axi_write(A_DEEP, m_deep, 4'hf);
      axi_write(A_CFG, m_cfg, 4'hf);
      read_check("deep_rw", A_DEEP, m_deep);
      read_check("sleep_rw", A_SLP, m_sleep);
      read_check("cfg_rw", A_CFG, m_cfg);
      for (int pw = 0; pw < 4; pw++)
      begin
        @(posedge i_clk);
        i_power <= dsgate_pkg::dsgate_power_s'(pw[1:0]);
        repeat (4) @(posedge i_clk);
        #1;
        check("enables", o_unit_clk_en, exp_en(pw[1:0]));
        check("deep_active", {31'h0, o_deep_active}, {31'h0, m_cfg[0] & pw[0]});
        read_check("status", A_STAT, exp_en(pw[1:0]));
        ev = exp_en(pw[1:0]);
        for (int u = 0; u < 32; u++)
          poke(u[4:0], ev[u]);
      end
    end
    // Clock enable low must freeze the mode and the enables
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_power <= '0;
    repeat (4) @(posedge i_clk);
    #1;
    check("enables_frozen", o_unit_clk_en, exp_en(2'd3));
    @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    check("enables_thawed", o_unit_clk_en, exp_en(2'd0));
    check("deep_thawed", {31'h0, o_deep_active}, 32'h0);
    tally_and_finish();
  end
endmodule
